// File: hdl/mwdt_pkg.sv
// Constants and types shared by the board watchdog timer.
// Assumes a 125 MHz core clock; all configuration arrives as plain ports.
// Operation
// - Reset action: request system reset on expiry
// - Pin action: timeout pin high on expiry
// - Interrupt action: signal NMI on expiry
// - Grace delay in seconds before counting
// - Timeout period counted in tenth seconds
package mwdt_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned MWDT_CLK_HZ = 125000000;
  localparam int unsigned MWDT_GRACE_UNIT_MS = 1000;
  localparam int unsigned MWDT_PERIOD_UNIT_MS = 100;
  localparam int unsigned MWDT_MS_CYCLES = MWDT_CLK_HZ / 1000;
  localparam int unsigned MWDT_TICK_CYCLES =
    MWDT_PERIOD_UNIT_MS * MWDT_MS_CYCLES;
  localparam int unsigned MWDT_TENTHS_PER_SEC =
    MWDT_GRACE_UNIT_MS / MWDT_PERIOD_UNIT_MS;

  // ==========================================================
  // Setting widths and defaults
  localparam int unsigned MWDT_DLY_W = 16;
  localparam logic [15:0] MWDT_GRACE_RST = 16'h012C;
  localparam logic [15:0] MWDT_PERIOD_RST = 16'h0096;

  // ==========================================================
  // Output action encoding
  typedef enum logic [1:0] {
    MWDT_ACT_RESET = 2'h0,
    MWDT_ACT_PIN = 2'h1,
    MWDT_ACT_NMI = 2'h2
  } mwdt_act_t;

  // ==========================================================
  // Controller states
  typedef enum logic [3:0] {
    MWDT_ST_IDLE = 4'h1,
    MWDT_ST_GRACE = 4'h2,
    MWDT_ST_COUNT = 4'h4,
    MWDT_ST_EXPIRED = 4'h8
  } mwdt_state_t;

endpackage

// File: hdl/mwdt_tick.sv
// Tenth-second tick generator for the board watchdog.
// Assumes a single core clock; runs only while enabled.
`timescale 1ns/1ps
module mwdt_tick
  import mwdt_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MWDT_TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Control
  input wire logic i_run,
  output logic o_tick
);

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } mwdt_tick_st_t;

  mwdt_tick_st_t st_q;
  mwdt_tick_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!i_run) begin
      st_d.cnt = 32'h0;
    end else if (st_q.cnt == TICK_CYCLES - 1) begin
      st_d.cnt = 32'h0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 32'h1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= '0;
    end else if (i_ce) begin
      st_q <= st_d;
    end
  end

  assign o_tick = st_q.tick & i_ce;

endmodule // mwdt_tick

// File: hdl/mwdt_top.sv
// Board watchdog timer: grace delay, timeout period, selectable action.
// Assumes settings are held steady by firmware; kick comes from core logic.
// Expired actions stay up until firmware clears the enable setting.
// Clock enable low freezes the whole block, tick source included.
// Action outputs are registered, status decoded from the state register; plain ports, no bus.
`timescale 1ns/1ps
module mwdt_top
  import mwdt_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MWDT_TICK_CYCLES,
  parameter int unsigned DLY_W = MWDT_DLY_W
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Configuration
  input wire logic i_enable,
  input wire logic [1:0] i_action_select,
  input wire logic [DLY_W-1:0] i_grace_secs,
  input wire logic [DLY_W-1:0] i_period_tenths,
  // Service
  input wire logic i_kick,
  // Actions
  output logic o_sys_reset_req,
  output logic o_timeout_output_pin,
  output logic o_nmi,
  // Status
  output logic o_counting,
  output logic o_expired
);

  // ==========================================================
  // Widths
  // Phase counter is four bits wider than the settings so the
  // grace target, seconds times ten, always fits
  localparam int unsigned CNT_W = DLY_W + 4;
  // One flag per action: reset, pin, interrupt
  localparam int unsigned N_ACT = 3;

  // ==========================================================
  // State
  typedef struct packed {
    mwdt_state_t state;
    logic [CNT_W-1:0] cnt;
    logic rst_req;
    logic pin;
    logic nmi;
  } mwdt_st_t;

  mwdt_st_t st_q;
  mwdt_st_t st_d;

  // ==========================================================
  // Internal signals
  logic tick;
  logic run;
  logic in_grace;
  logic in_count;
  logic in_expired;
  logic [CNT_W-1:0] grace_tenths;
  logic [CNT_W-1:0] period_tenths;
  logic [CNT_W-1:0] cnt_inc;
  logic [CNT_W-1:0] grace_cnt_nxt;
  logic [CNT_W-1:0] count_cnt_nxt;
  logic grace_done;
  logic period_done;
  logic [N_ACT-1:0] act_hit;

  // ==========================================================
  // Phase decode
  // One-hot state, each phase decoded by a full 4-bit compare of the state code
  assign in_grace = (st_q.state == MWDT_ST_GRACE);
  assign in_count = (st_q.state == MWDT_ST_COUNT);
  assign in_expired = (st_q.state == MWDT_ST_EXPIRED);

  // The tick source runs on from grace into count without a restart,
  // but grace ends with the tick counter at zero, so the first period tick is one full tick away
  assign run = i_enable && (in_grace || in_count);

  // ==========================================================
  // Tick source
  // Tenth-second ticks, held idle outside grace and count
  mwdt_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_run(run),
    .o_tick(tick)
  );

  // ==========================================================
  // Phase targets
  // Grace counted in tenths so one tick source serves both phases
  assign grace_tenths = CNT_W'(i_grace_secs) *
    CNT_W'(MWDT_TENTHS_PER_SEC);
  assign period_tenths = CNT_W'(i_period_tenths);

  // ==========================================================
  // Counter step
  // Saturates instead of wrapping, so a count that ran past its
  // target can never fall back below it
  always_comb begin
    if (&st_q.cnt) begin
      cnt_inc = st_q.cnt;
    end else begin
      cnt_inc = st_q.cnt + 1'h1;
    end
  end

  // ==========================================================
  // Next count per phase
  // Grace: ticks only, a kick is ignored until counting starts
  always_comb begin
    if (tick) begin
      grace_cnt_nxt = cnt_inc;
    end else begin
      grace_cnt_nxt = st_q.cnt;
    end
  end

  // Count: a kick restarts the period and wins over a tick
  always_comb begin
    if (i_kick) begin
      count_cnt_nxt = '0;
    end else if (tick) begin
      count_cnt_nxt = cnt_inc;
    end else begin
      count_cnt_nxt = st_q.cnt;
    end
  end

  // ==========================================================
  // Phase done
  // A zero setting ends its phase on the first cycle spent in it
  assign grace_done = (grace_cnt_nxt >= grace_tenths);
  assign period_done = (count_cnt_nxt >= period_tenths);

  // ==========================================================
  // Action decode
  // Code 3 is unassigned and falls back to the reset action, the
  // safest outcome for a system that has stopped responding
  for (genvar a = 0; a < N_ACT; a++) begin : g_act
    if (a == 0) begin : g_reset
      assign act_hit[a] = (i_action_select == MWDT_ACT_RESET) ||
        (&i_action_select);
    end else begin : g_other
      assign act_hit[a] = (i_action_select == 2'(a));
    end
  end

  // ==========================================================
  // Controller
  always_comb begin
    st_d = st_q;
    case (st_q.state)
      MWDT_ST_IDLE: begin
        st_d.cnt = '0;
        if (i_enable) begin
          st_d.state = MWDT_ST_GRACE;
        end
      end
      MWDT_ST_GRACE: begin
        if (grace_done) begin
          st_d.state = MWDT_ST_COUNT;
          st_d.cnt = '0;
        end else begin
          st_d.cnt = grace_cnt_nxt;
        end
      end
      MWDT_ST_COUNT: begin
        st_d.cnt = count_cnt_nxt;
        if (period_done) begin
          st_d.state = MWDT_ST_EXPIRED;
          st_d.rst_req = act_hit[0];
          st_d.pin = act_hit[1];
          st_d.nmi = act_hit[2];
        end
      end
      MWDT_ST_EXPIRED: begin
        // Action holds until disabled; no re-arm without firmware
        st_d.cnt = st_q.cnt;
      end
      default: begin
        // Any illegal code falls back to idle with the count cleared; action flags keep their value
        st_d.state = MWDT_ST_IDLE;
        st_d.cnt = '0;
      end
    endcase
    // Disable overrides every phase and clears the actions at once
    if (!i_enable) begin
      st_d.state = MWDT_ST_IDLE;
      st_d.cnt = '0;
      st_d.rst_req = 1'h0;
      st_d.pin = 1'h0;
      st_d.nmi = 1'h0;
    end
  end

  // ==========================================================
  // State register
  // Clock enable low freezes every field, the counter included
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= '{state: MWDT_ST_IDLE, default: '0};
    end else if (i_ce) begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs
  // The action lines come straight from register bits, so no
  // decode glitch can reach the reset, pin or interrupt lines
  assign o_sys_reset_req = st_q.rst_req;
  assign o_timeout_output_pin = st_q.pin;
  assign o_nmi = st_q.nmi;
  assign o_counting = in_count;
  assign o_expired = in_expired;

endmodule // mwdt_top

// File: tb/mwdt_sva.sv
// Port checker for mwdt_top, bound below.
// Assumes i_ce is dropped only while the block sits idle.
`timescale 1ns/1ps
module mwdt_sva (
  input wire logic i_core_clk, i_nrst, i_enable,
  input wire logic [1:0] i_action_select,
  input wire logic [15:0] i_grace_secs,
  input wire logic o_sys_reset_req, o_timeout_output_pin, o_nmi,
  input wire logic o_counting, o_expired
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  property p_off; !i_enable |=> !(o_counting | o_expired | o_nmi |
    o_sys_reset_req | o_timeout_output_pin); endproperty
  a_off: assert property (p_off) else $error("active while off");
  property p_rst; o_sys_reset_req == (o_expired && ~^i_action_select);
  endproperty
  a_rst: assert property (p_rst) else $error("reset request wrong");
  property p_pin; o_timeout_output_pin == (o_expired &&
    i_action_select == 2'h1); endproperty
  a_pin: assert property (p_pin) else $error("pin wrong");
  property p_nmi; o_nmi == (o_expired && i_action_select == 2'h2);
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi wrong");
  property p_grace; $rose(i_enable) && i_grace_secs != 16'h0 |=>
    !o_counting [*8]; endproperty
  a_grace: assert property (p_grace) else $error("grace too short");
  property p_per; $rose(o_expired) |-> $past(o_counting); endproperty
  a_per: assert property (p_per) else $error("expiry not from count");
endmodule // mwdt_sva
bind mwdt_top mwdt_sva mwdt_sva_i (.*);

// File: tb/mwdt_far.sv
// Far side: latches which action line fired since the last clear.
// Assumes the action lines are registered on the same clock.
`timescale 1ns/1ps
module mwdt_far (
  // Clock, reset and clear
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_clr,
  // Action lines
  input wire logic i_sys_reset_req,
  input wire logic i_pin,
  input wire logic i_nmi,
  // Seen flags: reset, pin, interrupt
  output logic [2:0] o_seen
);
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_seen <= 3'h0;
    end else if (i_clr) begin
      o_seen <= 3'h0;
    end else begin
      o_seen <= o_seen | {i_sys_reset_req, i_pin, i_nmi};
    end
  end
endmodule // mwdt_far

// File: tb/testbench.sv
// Self-checking bench for mwdt_top, tick shortened to 2 cycles.
// Assumes the design's outputs settle before each falling edge.
`timescale 1ns/1ps
module testbench;
  logic i_core_clk = 0, i_nrst = 0, i_enable = 0, i_kick = 0, clr = 0;
  logic ce = 1;
  logic [1:0] i_action_select = 0;
  logic [15:0] i_grace_secs = 0, i_period_tenths = 0;
  logic o_sys_reset_req, o_timeout_output_pin, o_nmi, o_counting, o_expired;
  logic [2:0] seen;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  always #4 i_core_clk = ~i_core_clk;
  mwdt_top #(.TICK_CYCLES(2)) mwdt_top_i (.i_core_clk, .i_nrst, .i_ce(ce),
    .i_enable, .i_action_select, .i_grace_secs, .i_period_tenths, .i_kick,
    .o_sys_reset_req, .o_timeout_output_pin, .o_nmi, .o_counting,
    .o_expired);
  mwdt_far mwdt_far_i (.i_core_clk, .i_nrst, .i_clr(clr),
    .i_sys_reset_req(o_sys_reset_req), .i_pin(o_timeout_output_pin),
    .i_nmi(o_nmi), .o_seen(seen));
  task chk(string n, logic [15:0] s, logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %0h got %0h", n, e, s);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Ceiling well above the fewer than two hundred cycles the run needs
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      wrap_up;
    end
  end
  task t_expire(input logic [1:0] s, input int g, input int p);
    int t, e;
    e = 20 * g + 2 * p;
    i_action_select = s;
    i_grace_secs = 16'(g);
    i_period_tenths = 16'(p);
    i_enable = 1;
    clr = 1;
    @(negedge i_core_clk) clr = 0;
    for (t = 1; t < 300 && o_expired !== 1'b1; t++) @(negedge i_core_clk);
    chk("delay", 16'(t >= e - 1 && t <= e + 3), 16'h1);
    @(negedge i_core_clk);
    chk("action", 16'(seen),
      16'(s == 1 ? 3'h2 : s == 2 ? 3'h1 : 3'h4));
    i_enable = 0;
    repeat (2) @(negedge i_core_clk);
    chk("off", {o_counting, o_expired, o_nmi, o_sys_reset_req,
      o_timeout_output_pin}, 16'h0);
  endtask
  task t_freeze;
    ce = 0;
    i_grace_secs = 0;
    i_period_tenths = 2;
    i_enable = 1;
    repeat (20) @(negedge i_core_clk);
    chk("frozen", {o_counting, o_expired}, 16'h0);
    ce = 1;
    repeat (8) @(negedge i_core_clk);
    chk("thawed", o_expired, 16'h1);
    i_enable = 0;
    repeat (2) @(negedge i_core_clk);
  endtask
  task t_kick;
    i_grace_secs = 0;
    i_period_tenths = 4;
    i_enable = 1;
    repeat (10) begin
      repeat (3) @(negedge i_core_clk);
      i_kick = 1;
      @(negedge i_core_clk) i_kick = 0;
    end
    chk("kicked", o_expired, 16'h0);
    chk("counting", o_counting, 16'h1);
    repeat (10) @(negedge i_core_clk);
    chk("unkicked", o_expired, 16'h1);
    i_enable = 0;
  endtask
  initial begin
    repeat (8) @(negedge i_core_clk);
    i_nrst = 1;
    t_expire(0, 1, 3);
    t_expire(1, 0, 0);
    t_expire(2, 0, 5);
    t_expire(3, 1, 1);
    t_freeze;
    t_kick;
    wrap_up;
  end
endmodule // testbench
